// *** verilog/alf_core.sv ***
// arithmetic, logic and flow execution unit
// assumes decoder gives op and operands with start pulse; one clock domain
`timescale 1ns/1ns
module alf_core
  import alf_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b1,
  parameter int PC_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [4:0] op,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] rdh_val,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_rdata,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [PC_W-1:0] offset,
  input wire logic [PC_W-1:0] z_ptr,
  input wire logic [PC_W-1:0] abs_addr,
  input wire logic next_two_word,
  output logic busy_r,
  output logic done_r,
  output logic [7:0] res_lo_r,
  output logic [7:0] res_hi_r,
  output logic wr_lo_r,
  output logic wr_hi_r,
  output logic prod_wr_r,
  output logic [7:0] sreg_r,
  output logic [PC_W-1:0] pc_r,
  output logic pc_load_r,
  output logic push_r,
  output logic [7:0] bus_addr_r,
  output logic [7:0] bit_mask_r,
  output logic bit_set_r,
  output logic bit_clr_r,
  output logic illegal_r
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} alf_st_e;
  alf_st_e st_r;
  logic [2:0] cnt_r;
  logic [2:0] cyc_nxt;
  logic [7:0] lo_nxt, hi_nxt, sreg_nxt;
  logic [PC_W-1:0] pc_nxt;
  logic wlo, whi, wprod, pcl, psh, bset, bclr, ill;
  logic [7:0] baddr;
  logic [15:0] prod;
  logic pcarry;
  logic [8:0] s9;
  logic [16:0] w17;
  logic [15:0] wsrc;

  function automatic logic [7:0] lg_flags(input logic [7:0] s, input logic [7:0] r);
    logic [7:0] f;
    f = s;
    f[FL_Z] = (r == 8'h00);
    f[FL_N] = r[7];
    f[FL_V] = 1'b0;
    f[FL_S] = r[7];
    return f;
  endfunction

  alf_mult u_mult (
    .a(rd_val),
    .b(rr_val),
    .a_signed(op == OP_MUL_SS || op == OP_MUL_SU || op == OP_FRAC_SS || op == OP_FRAC_SU),
    .b_signed(op == OP_MUL_SS || op == OP_FRAC_SS),
    .frac(op == OP_FRAC_UU || op == OP_FRAC_SS || op == OP_FRAC_SU),
    .prod(prod),
    .carry(pcarry)
  );

  // ****************************************
  // execution decode
  // ****************************************
  always_comb begin
    lo_nxt = 8'h00;
    hi_nxt = 8'h00;
    sreg_nxt = sreg_r;
    pc_nxt = pc_r;
    cyc_nxt = CYC_1;
    wlo = 1'b0;
    whi = 1'b0;
    wprod = 1'b0;
    pcl = 1'b0;
    psh = 1'b0;
    bset = 1'b0;
    bclr = 1'b0;
    ill = 1'b0;
    baddr = 8'h00;
    s9 = 9'h000;
    w17 = 17'h00000;
    wsrc = {rdh_val, rd_val};
    case (op)
      OP_ADD, OP_ADC: begin
        s9 = {1'b0, rd_val} + {1'b0, rr_val} + {8'h00, op == OP_ADC && sreg_r[FL_C]};
        lo_nxt = s9[7:0];
        wlo = 1'b1;
        sreg_nxt = lg_flags(sreg_r, s9[7:0]);
        sreg_nxt[FL_C] = s9[8];
        sreg_nxt[FL_V] = (rd_val[7] == rr_val[7]) && (s9[7] != rd_val[7]);
        sreg_nxt[FL_H] = (rd_val[3] & rr_val[3]) | (rr_val[3] & ~s9[3]) | (~s9[3] & rd_val[3]);
        sreg_nxt[FL_S] = sreg_r[FL_S];
      end
      OP_SUB, OP_SUBB: begin
        s9 = {1'b0, rd_val} - {1'b0, imm} - {8'h00, op == OP_SUBB && sreg_r[FL_C]};
        lo_nxt = s9[7:0];
        wlo = 1'b1;
        sreg_nxt = lg_flags(sreg_r, s9[7:0]);
        sreg_nxt[FL_C] = s9[8];
        sreg_nxt[FL_V] = (rd_val[7] != imm[7]) && (s9[7] != rd_val[7]);
        sreg_nxt[FL_H] = (~rd_val[3] & imm[3]) | (imm[3] & s9[3]) | (s9[3] & ~rd_val[3]);
        sreg_nxt[FL_S] = sreg_r[FL_S];
      end
      OP_AND, OP_OR, OP_XOR: begin
        // imm carries rr, the constant, or the complemented mask
        lo_nxt = (op == OP_AND) ? rd_val & imm : (op == OP_OR) ? rd_val | imm : rd_val ^ imm;
        wlo = 1'b1;
        sreg_nxt = lg_flags(sreg_r, lo_nxt);
        sreg_nxt[FL_S] = sreg_r[FL_S];
      end
      OP_INC, OP_DEC: begin
        lo_nxt = (op == OP_INC) ? rd_val + BYTE_ONE : rd_val - BYTE_ONE;
        wlo = 1'b1;
        sreg_nxt = lg_flags(sreg_r, lo_nxt);
        sreg_nxt[FL_S] = sreg_r[FL_S];
        sreg_nxt[FL_V] = (op == OP_INC) ? (rd_val == 8'h7F) : (rd_val == 8'h80);
      end
      OP_WADD, OP_WSUB: begin
        w17 = (op == OP_WADD) ? {1'b0, wsrc} + {9'h000, imm} : {1'b0, wsrc} - {9'h000, imm};
        lo_nxt = w17[7:0];
        hi_nxt = w17[15:8];
        wlo = 1'b1;
        whi = 1'b1;
        cyc_nxt = CYC_2;
        sreg_nxt[FL_Z] = (w17[15:0] == 16'h0000);
        sreg_nxt[FL_C] = w17[16];
        sreg_nxt[FL_N] = w17[15];
        sreg_nxt[FL_V] = (op == OP_WADD) ? (~rdh_val[7] & w17[15]) : (rdh_val[7] & ~w17[15]);
        sreg_nxt[FL_S] = w17[15] ^ sreg_nxt[FL_V];
      end
      OP_MUL, OP_MUL_SS, OP_MUL_SU, OP_FRAC_UU, OP_FRAC_SS, OP_FRAC_SU: begin
        lo_nxt = prod[7:0];
        hi_nxt = prod[15:8];
        wprod = 1'b1;
        cyc_nxt = CYC_2;
        sreg_nxt[FL_C] = pcarry;
        sreg_nxt[FL_Z] = (prod == 16'h0000);
      end
      OP_REL_JUMP, OP_REL_CALL: begin
        pc_nxt = pc_in + offset + PC_ONE;
        pcl = 1'b1;
        psh = (op == OP_REL_CALL);
        cyc_nxt = (op == OP_REL_CALL) ? CYC_3 : CYC_2;
      end
      OP_IJMP, OP_ICALL: begin
        pc_nxt = z_ptr;
        pcl = 1'b1;
        psh = (op == OP_ICALL);
        cyc_nxt = (op == OP_ICALL) ? CYC_3 : CYC_2;
      end
      OP_JMP, OP_CALL: begin
        if (LARGE_MEM) begin
          pc_nxt = abs_addr;
          pcl = 1'b1;
          psh = (op == OP_CALL);
          cyc_nxt = (op == OP_CALL) ? CYC_4 : CYC_3;
        end else begin
          ill = 1'b1;
        end
      end
      OP_EQ_SKIP, OP_SKIPHI, OP_SKIPLO: begin
        if (op == OP_SKIPHI || op == OP_SKIPLO) begin
          ill = (io_addr > IO_BIT_LAST);
          baddr = io_addr + IO_DATA_OFS;
        end
        if (!ill && ((op == OP_EQ_SKIP && rd_val == rr_val) || (op == OP_SKIPHI && io_rdata[bit_sel]) ||
            (op == OP_SKIPLO && !io_rdata[bit_sel]))) begin
          pc_nxt = pc_in + (next_two_word ? PC_ONE + PC_ONE + PC_ONE : PC_ONE + PC_ONE);
          pcl = 1'b1;
          cyc_nxt = next_two_word ? CYC_3 : CYC_2;
        end
      end
      OP_IOSET, OP_IOCLR: begin
        ill = (io_addr > IO_BIT_LAST);
        baddr = io_addr + IO_DATA_OFS;
        bset = !ill && op == OP_IOSET;
        bclr = !ill && op == OP_IOCLR;
        cyc_nxt = CYC_2;
      end
      OP_IOIN, OP_IOOUT: begin
        ill = (io_addr > IO_LAST);
        baddr = io_addr + IO_DATA_OFS;
        lo_nxt = io_rdata;
        wlo = !ill && op == OP_IOIN;
      end
      OP_DLOAD, OP_DSTORE: begin
        baddr = io_addr;
        lo_nxt = io_rdata;
        wlo = (op == OP_DLOAD);
      end
      default: ill = 1'b1;
    endcase
    if (ill) begin
      wlo = 1'b0;
      whi = 1'b0;
      sreg_nxt = sreg_r;
      pcl = 1'b0;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 3'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      done_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (start) begin
            if (cyc_nxt == CYC_1) begin
              done_r <= 1'b1;
            end else begin
              st_r <= ST_RUN;
              busy_r <= 1'b1;
              cnt_r <= cyc_nxt - CYC_1;
            end
          end
        end
        ST_RUN: begin
          cnt_r <= cnt_r - CYC_1;
          if (cnt_r == CYC_1) begin
            st_r <= ST_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // results, status and program counter
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_lo_r <= 8'h00;
      res_hi_r <= 8'h00;
      wr_lo_r <= 1'b0;
      wr_hi_r <= 1'b0;
      prod_wr_r <= 1'b0;
      sreg_r <= SREG_RST;
      pc_r <= '0;
      pc_load_r <= 1'b0;
      push_r <= 1'b0;
      bus_addr_r <= 8'h00;
      bit_mask_r <= 8'h00;
      bit_set_r <= 1'b0;
      bit_clr_r <= 1'b0;
      illegal_r <= 1'b0;
    end else if (clk_en) begin
      wr_lo_r <= 1'b0;
      wr_hi_r <= 1'b0;
      prod_wr_r <= 1'b0;
      pc_load_r <= 1'b0;
      push_r <= 1'b0;
      bit_set_r <= 1'b0;
      bit_clr_r <= 1'b0;
      illegal_r <= 1'b0;
      if (st_r == ST_IDLE && start) begin
        res_lo_r <= lo_nxt;
        res_hi_r <= hi_nxt;
        wr_lo_r <= wlo;
        wr_hi_r <= whi;
        prod_wr_r <= wprod && !ill;
        sreg_r <= sreg_nxt;
        pc_r <= pc_nxt;
        pc_load_r <= pcl;
        push_r <= psh && !ill;
        bus_addr_r <= baddr;
        bit_mask_r <= 8'h01 << bit_sel;
        bit_set_r <= bset;
        bit_clr_r <= bclr;
        illegal_r <= ill;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_ADD_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st_r == ST_IDLE && start && op == OP_ADD |=> done_r && res_lo_r == $past(rd_val) + $past(rr_val))
    else $error("add result or timing wrong");
  AST_SUB_BORROW: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st_r == ST_IDLE && start && op == OP_SUB |=> sreg_r[FL_C] == ($past(imm) > $past(rd_val)))
    else $error("borrow flag wrong");
  AST_SUB_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st_r == ST_IDLE && start && op == OP_SUB |=> done_r && !busy_r)
    else $error("subtract not single cycle");
  AST_WORD_TWO: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st_r == ST_IDLE && start && op == OP_WADD ##1 clk_en |=> done_r)
    else $error("word op not two cycles");
  AST_LOGIC_V: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st_r == ST_IDLE && start && op == OP_XOR |=> !sreg_r[FL_V] && sreg_r[FL_C] == $past(sreg_r[FL_C]))
    else $error("logic flags wrong");
  AST_MUL_PAIR: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st_r == ST_IDLE && start && op == OP_MUL |=> {res_hi_r, res_lo_r} == $past(rd_val) * $past(rr_val))
    else $error("product wrong");
  AST_REL_JUMP_PC: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st_r == ST_IDLE && start && op == OP_REL_JUMP |=>
    pc_load_r && pc_r == $past(pc_in) + $past(offset) + PC_ONE)
    else $error("relative target wrong");
  AST_NOFLAG: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && st_r == ST_IDLE && start && op == OP_IJMP |=> $stable(sreg_r))
    else $error("flow op changed status");
  AST_BIT_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
    bit_set_r |-> bus_addr_r <= IO_BIT_LAST + IO_DATA_OFS && $onehot(bit_mask_r))
    else $error("bit op outside low io");
  COV_MUL: cover property (@(posedge clk) prod_wr_r);
  COV_CALL: cover property (@(posedge clk) push_r);
  COV_SKIP: cover property (@(posedge clk) pc_load_r && !push_r);
  COV_BIT: cover property (@(posedge clk) bit_clr_r);
endmodule // alf_core

// *** verilog/alf_pkg.sv ***
// package for the arithmetic, logic and flow unit
// assumes one 25 MHz clock domain and an instruction decoder upstream
//
// Contract
// - add two registers in one cycle, carry variant adds c; z c n v h
// - subtract register or constant, optional borrow, one cycle; z c n v h
// - word add or subtract of constant on pair, two cycles; z c n v s
// - and, or, xor of registers, and/or with constant, one cycle; z n v
// - mask set by or, mask clear by and with ff minus mask; z n v
// - increment, decrement, test and clear in one cycle; only z n v
// - unsigned, signed, mixed 8x8 product to pair, high byte high; two cycles
// - fractional products shifted left one before writing pair; two cycles
// - relative jump to pc plus offset plus one in two; call in three
// - indirect jump from z pointer in two cycles; call in three
// - direct jump three cycles, call four, large variant only, no flags
// - compare-equal skip takes one, two or three cycles; no flags
// - io 0x00 to 0x1F allow bit set, clear and bit-test skips
// - bit set or clear touches only the addressed bit
// - io instructions reach 0x00 to 0x3F; data space adds 0x20
// - extended region 0x60 to 0xFF reachable only by data load/store
package alf_pkg;
  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_ADC = 5'h01, OP_SUB = 5'h02, OP_SUBB = 5'h03,
    OP_AND = 5'h04, OP_OR = 5'h05, OP_XOR = 5'h06, OP_INC = 5'h07,
    OP_DEC = 5'h08, OP_WADD = 5'h09, OP_WSUB = 5'h0A, OP_MUL = 5'h0B,
    OP_MUL_SS = 5'h0C, OP_MUL_SU = 5'h0D, OP_FRAC_UU = 5'h0E, OP_FRAC_SS = 5'h0F,
    OP_FRAC_SU = 5'h10, OP_REL_JUMP = 5'h11, OP_REL_CALL = 5'h12, OP_IJMP = 5'h13,
    OP_ICALL = 5'h14, OP_JMP = 5'h15, OP_CALL = 5'h16, OP_EQ_SKIP = 5'h17,
    OP_IOSET = 5'h18, OP_IOCLR = 5'h19, OP_SKIPHI = 5'h1A, OP_SKIPLO = 5'h1B,
    OP_IOIN = 5'h1C, OP_IOOUT = 5'h1D, OP_DLOAD = 5'h1E, OP_DSTORE = 5'h1F
  } alf_op_e;
  // status bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam logic [7:0] SREG_RST = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  // io map
  localparam logic [7:0] IO_BIT_LAST = 8'h1F;
  localparam logic [7:0] IO_LAST = 8'h3F;
  localparam logic [7:0] IO_DATA_OFS = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hFF;
  // cycle counts
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [15:0] PC_ONE = 16'h0001;
endpackage

// *** verilog/alf_mult.sv ***
// 8x8 multiplier with signedness and fractional shift
// assumes operands held stable by the caller during the op
`timescale 1ns/1ns
module alf_mult
  import alf_pkg::*;
(
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic a_signed,
  input wire logic b_signed,
  input wire logic frac,
  output logic [15:0] prod,
  output logic carry
);
  logic signed [17:0] full;
  logic [15:0] raw;
  always_comb begin
    full = $signed({a_signed & a[7], a_signed & a[7], a}) * $signed({b_signed & b[7], b_signed & b[7], b});
    raw = full[15:0];
    carry = raw[15];
    prod = frac ? {raw[14:0], 1'b0} : raw;
  end
endmodule // alf_mult

// *** verification/test_arith_logic_and_flow_unit.sv ***
// self-checking bench for the arithmetic, logic and flow unit
// assumes alf_pkg and alf_core compiled first; inputs driven on falling edges
`timescale 1ns/1ns
module test_arith_logic_and_flow_unit;
  import alf_pkg::*;
  logic clk, rst_n, start, next_two_word, clk_en, small_ill, small_pcl;
  logic [1:0] small_seen;
  logic [4:0] op;
  logic [7:0] rd_val, rr_val, rdh_val, imm, io_addr, io_rdata, res_lo_r, res_hi_r, sreg_r, bus_addr_r, bit_mask_r;
  logic [2:0] bit_sel;
  logic [15:0] pc_in, offset, z_ptr, abs_addr, pc_r;
  logic busy_r, done_r, wr_lo_r, wr_hi_r, prod_wr_r, pc_load_r, push_r, bit_set_r, bit_clr_r, illegal_r;
  logic [7:0] seen;
  logic [7:0] keep;
  int miscompares, cmp_count, cyc;

  alf_core dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .start(start), .op(op), .rd_val(rd_val),
    .rr_val(rr_val), .rdh_val(rdh_val), .imm(imm), .bit_sel(bit_sel), .io_addr(io_addr), .io_rdata(io_rdata),
    .pc_in(pc_in), .offset(offset), .z_ptr(z_ptr), .abs_addr(abs_addr), .next_two_word(next_two_word),
    .busy_r(busy_r), .done_r(done_r), .res_lo_r(res_lo_r), .res_hi_r(res_hi_r), .wr_lo_r(wr_lo_r),
    .wr_hi_r(wr_hi_r), .prod_wr_r(prod_wr_r), .sreg_r(sreg_r), .pc_r(pc_r), .pc_load_r(pc_load_r),
    .push_r(push_r), .bus_addr_r(bus_addr_r), .bit_mask_r(bit_mask_r), .bit_set_r(bit_set_r),
    .bit_clr_r(bit_clr_r), .illegal_r(illegal_r));

  // small memory variant, watched in the flow test for direct jump refusal and for pc loads on the other flow ops
  alf_core #(.LARGE_MEM(1'b0)) small_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .start(start), .op(op),
    .rd_val(rd_val), .rr_val(rr_val), .rdh_val(rdh_val), .imm(imm), .bit_sel(bit_sel), .io_addr(io_addr),
    .io_rdata(io_rdata), .pc_in(pc_in), .offset(offset), .z_ptr(z_ptr), .abs_addr(abs_addr),
    .next_two_word(next_two_word), .busy_r(), .done_r(), .res_lo_r(), .res_hi_r(), .wr_lo_r(), .wr_hi_r(),
    .prod_wr_r(), .sreg_r(), .pc_r(), .pc_load_r(small_pcl), .push_r(), .bus_addr_r(), .bit_mask_r(),
    .bit_set_r(), .bit_clr_r(), .illegal_r(small_ill));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // issue one op, gather pulses, count cycles to completion
  task automatic run(input logic [4:0] o);
    int k;
    @(negedge clk);
    op = o;
    start = 1'b1;
    seen = 8'h00;
    small_seen = 2'b00;
    cyc = 0;
    for (k = 1; k <= 8 && cyc == 0; k++) begin
      @(negedge clk);
      start = 1'b0;
      seen = seen | {illegal_r, bit_clr_r, bit_set_r, push_r, pc_load_r, prod_wr_r, wr_hi_r, wr_lo_r};
      small_seen = small_seen | {small_ill, small_pcl};
      if (done_r === 1'b1 || illegal_r === 1'b1) cyc = k;
    end
    for (k = 0; k < 8 && busy_r !== 1'b0; k++) @(negedge clk);
    if (cyc == 0 || busy_r !== 1'b0) begin
      miscompares++;
      $display("ERROR %0t op did not complete", $time);
      test_done();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_add();
    logic [4:0] o [4] = '{OP_ADD, OP_ADD, OP_ADC, OP_ADD};
    logic [7:0] a [4] = '{8'h0F, 8'hFF, 8'h01, 8'h7F};
    logic [7:0] b [4] = '{8'h01, 8'h01, 8'h01, 8'h01};
    logic [7:0] e [4] = '{8'h10, 8'h00, 8'h03, 8'h80};
    logic [7:0] f [4] = '{8'h20, 8'h23, 8'h00, 8'h2C};
    for (int i = 0; i < 4; i++) begin
      rd_val = a[i]; rr_val = b[i]; imm = b[i];
      run(o[i]);
      chk(res_lo_r, e[i], "add result");
      chk(sreg_r & 8'h2F, f[i], "add flags");
      chk({seen[0], 4'(cyc)}, 5'h11, "add write and cycles");
    end
    $display("test add done");
  endtask

  task automatic t_sub();
    logic [4:0] o [4] = '{OP_SUB, OP_SUB, OP_SUBB, OP_SUB};
    logic [7:0] a [4] = '{8'h10, 8'h00, 8'h05, 8'h80};
    logic [7:0] e [4] = '{8'h0F, 8'hFF, 8'h03, 8'h7F};
    logic [7:0] f [4] = '{8'h20, 8'h25, 8'h00, 8'h28};
    for (int i = 0; i < 4; i++) begin
      rd_val = a[i]; rr_val = 8'h01; imm = 8'h01;
      run(o[i]);
      chk(res_lo_r, e[i], "sub result");
      chk(sreg_r & 8'h2F, f[i], "sub flags");
      chk(4'(cyc), 4'h1, "sub cycles");
    end
    $display("test sub done");
  endtask

  task automatic t_logic();
    logic [4:0] o [9] = '{OP_AND, OP_OR, OP_XOR, OP_AND, OP_OR, OP_AND, OP_INC, OP_INC, OP_DEC};
    logic [7:0] a [9] = '{8'hF0, 8'h80, 8'hAA, 8'hFF, 8'h10, 8'h80, 8'hFF, 8'h7F, 8'h01};
    logic [7:0] m [9] = '{8'h0F, 8'h01, 8'hAA, 8'hFF - 8'h0F, 8'h01, 8'h80, 8'h00, 8'h00, 8'h00};
    logic [7:0] e [9] = '{8'h00, 8'h81, 8'h00, 8'hF0, 8'h11, 8'h80, 8'h00, 8'h80, 8'h00};
    logic [7:0] f [9] = '{8'h02, 8'h04, 8'h02, 8'h04, 8'h00, 8'h04, 8'h02, 8'h0C, 8'h02};
    logic [7:0] k [9] = '{8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h0E};
    rd_val = 8'h00; rr_val = 8'h01; imm = 8'h01;
    run(OP_SUB);
    for (int i = 0; i < 9; i++) begin
      rd_val = a[i]; rr_val = m[i]; imm = m[i];
      run(o[i]);
      chk(res_lo_r, e[i], "logic result");
      chk(sreg_r & k[i], f[i], "logic flags");
      chk(sreg_r & 8'h21, 8'h21, "carry and half kept");
      chk(4'(cyc), 4'h1, "logic cycles");
    end
    $display("test logic done");
  endtask

  task automatic t_word();
    logic [4:0] o [3] = '{OP_WADD, OP_WSUB, OP_WADD};
    logic [15:0] a [3] = '{16'h00FF, 16'h0000, 16'hFFFF};
    logic [15:0] e [3] = '{16'h0100, 16'hFFFF, 16'h0000};
    logic [7:0] f [3] = '{8'h00, 8'h15, 8'h03};
    for (int i = 0; i < 3; i++) begin
      {rdh_val, rd_val} = a[i]; imm = 8'h01;
      run(o[i]);
      chk({res_hi_r, res_lo_r}, e[i], "word result");
      chk(sreg_r & 8'h1F, f[i], "word flags");
      chk({seen[1:0], 4'(cyc)}, 6'h32, "word writes and cycles");
    end
    $display("test word done");
  endtask

  // word op stalled by the clock enable in its second cycle
  task automatic t_freeze();
    int k;
    {rdh_val, rd_val} = 16'h0001;
    imm = 8'h01;
    @(negedge clk);
    op = OP_WADD;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    clk_en = 1'b0;
    for (k = 0; k < 3; k++) begin
      @(negedge clk);
      chk({busy_r, done_r}, 2'b10, "held while enable low");
    end
    clk_en = 1'b1;
    @(negedge clk);
    chk({busy_r, done_r, res_lo_r}, {2'b01, 8'h02}, "word op resumes");
    $display("test freeze done");
  endtask

  task automatic t_mul();
    logic [4:0] o [7] = '{OP_MUL, OP_MUL_SS, OP_MUL_SU, OP_FRAC_UU, OP_FRAC_SS, OP_FRAC_SU, OP_MUL};
    logic [7:0] a [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h80, 8'h80, 8'hFF, 8'h00};
    logic [7:0] b [7] = '{8'hFF, 8'hFF, 8'h02, 8'h80, 8'h80, 8'h80, 8'h55};
    logic [15:0] e [7] = '{16'hFE01, 16'h0001, 16'hFFFE, 16'h8000, 16'h8000, 16'hFF00, 16'h0000};
    logic [7:0] f [7] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02};
    for (int i = 0; i < 7; i++) begin
      rd_val = a[i]; rr_val = b[i]; imm = b[i];
      run(o[i]);
      chk({res_hi_r, res_lo_r}, e[i], "product");
      chk(sreg_r & 8'h03, f[i], "product flags");
      chk({seen[2], 4'(cyc)}, 5'h12, "product write and cycles");
    end
    $display("test multiply done");
  endtask

  task automatic t_flow();
    logic [4:0] o [6] = '{OP_REL_JUMP, OP_REL_CALL, OP_IJMP, OP_ICALL, OP_JMP, OP_CALL};
    logic [15:0] d [6] = '{16'h0010, 16'hFFF0, 16'h0010, 16'h0010, 16'h0010, 16'h0010};
    logic [15:0] e [6] = '{16'h0111, 16'h00F1, 16'h1234, 16'h1234, 16'h2345, 16'h2345};
    logic [5:0] c [6] = '{6'h12, 6'h33, 6'h12, 6'h33, 6'h13, 6'h34};
    pc_in = 16'h0100; z_ptr = 16'h1234; abs_addr = 16'h2345;
    for (int i = 0; i < 6; i++) begin
      offset = d[i];
      keep = sreg_r;
      run(o[i]);
      chk(pc_r, e[i], "jump target");
      chk({seen[4:3], 4'(cyc)}, c[i], "load, push and cycles");
      chk(small_seen, (i >= 4) ? 2'b10 : 2'b01, "small variant direct refusal");
      chk(sreg_r, keep, "flow keeps status");
    end
    $display("test flow done");
  endtask

  task automatic t_skip();
    logic [4:0] o [6] = '{OP_EQ_SKIP, OP_EQ_SKIP, OP_EQ_SKIP, OP_SKIPHI, OP_SKIPLO, OP_SKIPLO};
    logic [7:0] b [6] = '{8'h5A, 8'h5A, 8'h5B, 8'h80, 8'h80, 8'h7F};
    logic t [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    int n [6] = '{2, 3, 1, 2, 1, 3};
    rd_val = 8'h5A; io_addr = 8'h1F; bit_sel = 3'h7;
    for (int i = 0; i < 6; i++) begin
      rr_val = b[i]; imm = b[i]; io_rdata = b[i]; next_two_word = t[i];
      keep = sreg_r;
      run(o[i]);
      chk(16'(cyc), 16'(n[i]), "skip cycles");
      if (n[i] > 1) chk(pc_r, pc_in + 16'(n[i]), "skip target");
      chk(sreg_r, keep, "skip keeps status");
    end
    $display("test skip done");
  endtask

  task automatic t_io();
    logic [4:0] o [9] = '{OP_IOSET, OP_IOCLR, OP_IOSET, OP_IOOUT, OP_IOIN, OP_IOOUT, OP_IOIN, OP_DSTORE, OP_DLOAD};
    logic w [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [7:0] a [9] = '{8'h1F, 8'h00, 8'h20, 8'h3F, 8'h00, 8'h40, 8'h60, 8'h60, 8'hFF};
    logic [7:0] e [9] = '{8'h00, 8'h00, 8'h00, 8'h5F, 8'h20, 8'h00, 8'h00, 8'h60, 8'hFF};
    logic [2:0] p [9] = '{3'b001, 3'b010, 3'b100, 3'b000, 3'b000, 3'b100, 3'b100, 3'b000, 3'b000};
    for (int i = 0; i < 9; i++) begin
      io_addr = a[i]; bit_sel = 3'(i + 3); io_rdata = 8'hA5;
      run(o[i]);
      chk(seen[7:5], {p[i][2], p[i][1], p[i][0]}, "io pulses");
      if (i < 2) chk(bit_mask_r, 8'h01 << (i + 3), "single bit mask");
      if (e[i] != 8'h00) chk(bus_addr_r, e[i], "data space address");
      chk(seen[0], w[i], "register write only on load");
      if (w[i]) chk(res_lo_r, 8'hA5, "loaded byte");
    end
    $display("test io done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0; start = 1'b0; op = 5'h00; next_two_word = 1'b0; clk_en = 1'b1;
    rd_val = 8'h00; rr_val = 8'h00; rdh_val = 8'h00; imm = 8'h00; io_addr = 8'h00; io_rdata = 8'h00;
    bit_sel = 3'h0; pc_in = 16'h0000; offset = 16'h0000; z_ptr = 16'h0000; abs_addr = 16'h0000;
    miscompares = 0; cmp_count = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk({sreg_r, 7'h00, busy_r}, 16'h0000, "reset state");
    t_add();
    t_sub();
    t_logic();
    t_word();
    t_freeze();
    t_mul();
    t_flow();
    t_skip();
    t_io();
    test_done();
  end
endmodule // test_arith_logic_and_flow_unit
